// ==== design/cpm_pin_mux.sv ====
module cpm_pin_mux (
   input  wire logic                              clk,
   input  wire logic                              rst_n,
   input  wire logic                              clk_en,
   input  wire cpm_pkg::cpm_port_cfg_type         port_cfg,
   input  wire cpm_pkg::cpm_alt_cfg_type          alt_cfg,
   input  wire cpm_pkg::cpm_periph_out_type       periph_out,
   input  wire logic [cpm_pkg::NUM_PINS-1:0]      pin_in,
   output logic      [cpm_pkg::NUM_PINS-1:0]      pin_out,
   output logic      [cpm_pkg::NUM_PINS-1:0]      pin_oe,
   output logic      [cpm_pkg::NUM_PINS-1:0]      pin_pullup,
   output logic      [cpm_pkg::NUM_PINS-1:0]      port_read_q,
   output logic      [cpm_pkg::NUM_PINS-1:0]      change_flag_q,
   input  wire logic [cpm_pkg::NUM_PINS-1:0]      change_clear,
   output logic      [cpm_pkg::NUM_CH-1:0]        adc_channel_select,
   output logic                                   timer_ext_clock_q,
   output logic                                   ext_interrupt_q,
   output logic                                   master_clear_n_q,
   output logic                                   sync_in_q,
   output logic                                   scl_in_q,
   output logic                                   sda_in_q,
   output logic                                   prog_clock_q,
   output logic                                   prog_data_in_q,
   output logic                                   ccd_capture_q,
   output logic                                   ref2_to_pin_b1,
   output logic                                   sense_pullup_on,
   output logic                                   desat_to_comparator,
   output logic                                   sense_amp_int_feedback,
   output logic                                   sense_amp_to_pin
);
   localparam int N = cpm_pkg::NUM_PINS;
   localparam int P = cpm_pkg::PRIME_DEPTH;

   logic [N-1:0] pin_sync;
   logic [P-1:0] prime_q;
   logic [N-1:0] prev_q;
   logic [N-1:0] alt_own;
   logic [N-1:0] alt_oe;
   logic [N-1:0] alt_val;
   logic         role_main;
   logic         role_sync;

   function automatic logic role_is(input logic [1:0] f, input logic [1:0] r);
      return f == r;
   endfunction

   cpm_sync #(.WIDTH(N)) u_sync (
      .clk      (clk),
      .rst_n    (rst_n),
      .clk_en   (clk_en),
      .async_in (pin_in),
      .sync_out (pin_sync)
   );

   // role decode from the two-bit field
   assign role_main = role_is(alt_cfg.unit_role_field,
                              cpm_pkg::ROLE_MAIN);
   assign role_sync = role_main | role_is(alt_cfg.unit_role_field,
                              cpm_pkg::ROLE_SECONDARY);

   // alternate function ownership and drive
   always_comb begin
      alt_own = '0;
      alt_oe  = '0;
      alt_val = '0;
      if (alt_cfg.test_out_enable) begin
         alt_own[cpm_pkg::PIN_A0] = 1'b1;
         alt_oe[cpm_pkg::PIN_A0]  = 1'b1;
         alt_val[cpm_pkg::PIN_A0] = periph_out.test_out;
      end
      if (role_sync) begin
         // main drives the sync pin, secondary listens
         alt_own[cpm_pkg::PIN_A1] = 1'b1;
         alt_oe[cpm_pkg::PIN_A1]  = role_main;
         alt_val[cpm_pkg::PIN_A1] = periph_out.sync_out;
      end
      if (role_main) begin
         // analog reference takes the pin; digital driver off
         alt_own[cpm_pkg::PIN_B1] = 1'b1;
      end
      if (alt_cfg.ccd_a6_enable) begin
         alt_own[cpm_pkg::PIN_A6] = 1'b1;
         alt_oe[cpm_pkg::PIN_A6]  = periph_out.ccd_a6_oe;
         alt_val[cpm_pkg::PIN_A6] = periph_out.ccd_a6_out;
      end
      if (alt_cfg.ccd_b7_enable) begin
         // single compare output, capture reads pin_sync
         alt_own[cpm_pkg::PIN_B7] = 1'b1;
         alt_oe[cpm_pkg::PIN_B7]  = 1'b1;
         alt_val[cpm_pkg::PIN_B7] = periph_out.ccd_b7_out;
      end
      if (alt_cfg.two_wire_enable) begin
         // open drain: only ever pulls low
         alt_own[cpm_pkg::PIN_A7] = 1'b1;
         alt_oe[cpm_pkg::PIN_A7]  = periph_out.scl_drive_low;
         alt_own[cpm_pkg::PIN_B0] = 1'b1;
         alt_oe[cpm_pkg::PIN_B0]  = periph_out.sda_drive_low;
      end
      if (alt_cfg.prog_mode) begin
         // programmer owns the clock; data turns round on request
         alt_own[cpm_pkg::PIN_A6] = 1'b1;
         alt_oe[cpm_pkg::PIN_A6]  = periph_out.prog_data_oe;
         alt_val[cpm_pkg::PIN_A6] = periph_out.prog_data_out;
         alt_own[cpm_pkg::PIN_A7] = 1'b1;
         alt_oe[cpm_pkg::PIN_A7]  = 1'b0;
         if (alt_cfg.large_variant) begin
            alt_own[cpm_pkg::PIN_B4] = 1'b1;
            alt_oe[cpm_pkg::PIN_B4]  = periph_out.prog_data_oe;
            alt_val[cpm_pkg::PIN_B4] = periph_out.prog_data_out;
            alt_own[cpm_pkg::PIN_B5] = 1'b1;
            alt_oe[cpm_pkg::PIN_B5]  = 1'b0;
         end
      end
      if (alt_cfg.master_clear_enable) begin
         alt_own[cpm_pkg::PIN_A5] = 1'b1;
      end
   end

   // per-pin drive; open-drain pins never drive high
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_pin
         logic gp_oe;
         logic gp_val;
         assign gp_oe  = alt_own[g] ? alt_oe[g]
                                    : ~port_cfg.port_direction[g];
         assign gp_val = alt_own[g] ? alt_val[g]
                                    : port_cfg.port_latch[g];
         if (cpm_pkg::INPUT_ONLY_MASK[g]) begin : g_in
            assign pin_oe[g]  = 1'b0;
            assign pin_out[g] = 1'b0;
         end else if (cpm_pkg::OPEN_DRAIN_MASK[g]) begin : g_od
            assign pin_oe[g]  = gp_oe & ~(gp_val & ~alt_own[g]);
            assign pin_out[g] = 1'b0;
         end else begin : g_pp
            assign pin_oe[g]  = gp_oe;
            assign pin_out[g] = gp_val;
         end
         if (cpm_pkg::OPEN_DRAIN_MASK[g]) begin : g_nopu
            assign pin_pullup[g] = 1'b0;
         end else begin : g_pu
            // pull-up only while the pin is an input
            assign pin_pullup[g] = port_cfg.pullup_enable[g]
                                 & ~pin_oe[g]
                                 & ~alt_own[g];
         end
      end
   endgenerate

   // converter channels
   generate
      for (g = 0; g < cpm_pkg::NUM_CH; g++) begin : g_ch
         assign adc_channel_select[g] =
            port_cfg.port_direction[cpm_pkg::CH_PIN[g]]
            & port_cfg.analog_select[cpm_pkg::CH_PIN[g]];
      end
   endgenerate

   assign ref2_to_pin_b1         = role_main;
   assign sense_pullup_on        = alt_cfg.sense_input_pullup_enable;
   assign desat_to_comparator    = alt_cfg.desat_enable;
   assign sense_amp_int_feedback = alt_cfg.desat_enable;
   assign sense_amp_to_pin       = ~alt_cfg.desat_enable;

   // port read; analog pins read zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         port_read_q <= '0;
      end else if (clk_en) begin
         port_read_q <= pin_sync & ~port_cfg.analog_select;
      end
   end

   // pipeline fill after reset; stale zeros would fake edges
   // limitation: a pin change before the first enabled edge after reset is not flagged
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prime_q <= '0;
      end else if (clk_en) begin
         prime_q <= {prime_q[P-2:0], 1'b1};
      end
   end

   // interrupt-on-change; a set in the clear cycle wins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_q        <= '0;
         change_flag_q <= '0;
      end else if (clk_en) begin
         prev_q        <= pin_sync;
         change_flag_q <= (change_flag_q & ~change_clear)
                        | ((pin_sync ^ prev_q)
                           & port_cfg.change_enable
                           & {N{prime_q[P-1]}});
      end
   end

   // digital alternate inputs; masters hold their idle level
   // held at idle until the synchroniser carries real pin levels
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         timer_ext_clock_q <= 1'b0;
         ext_interrupt_q   <= 1'b0;
         master_clear_n_q  <= 1'b1;
         sync_in_q         <= 1'b0;
         scl_in_q          <= 1'b1;
         sda_in_q          <= 1'b1;
         prog_clock_q      <= 1'b0;
         prog_data_in_q    <= 1'b0;
         ccd_capture_q     <= 1'b0;
      end else if (clk_en && prime_q[P-2]) begin
         timer_ext_clock_q <= alt_cfg.timer_clock_source_select
                            & pin_sync[cpm_pkg::PIN_A2];
         ext_interrupt_q   <= alt_cfg.external_interrupt_enable
                            & pin_sync[cpm_pkg::PIN_A2];
         master_clear_n_q  <= ~alt_cfg.master_clear_enable
                            | pin_sync[cpm_pkg::PIN_A5];
         sync_in_q         <= role_sync & ~role_main
                            & pin_sync[cpm_pkg::PIN_A1];
         scl_in_q          <= ~alt_cfg.two_wire_enable
                            | pin_sync[cpm_pkg::PIN_A7];
         sda_in_q          <= ~alt_cfg.two_wire_enable
                            | pin_sync[cpm_pkg::PIN_B0];
         if (alt_cfg.prog_mode && alt_cfg.large_variant) begin
            prog_clock_q   <= pin_sync[cpm_pkg::PIN_B5]
                            | pin_sync[cpm_pkg::PIN_A7];
            prog_data_in_q <= pin_sync[cpm_pkg::PIN_B4]
                            | pin_sync[cpm_pkg::PIN_A6];
         end else begin
            prog_clock_q   <= alt_cfg.prog_mode
                            & pin_sync[cpm_pkg::PIN_A7];
            prog_data_in_q <= alt_cfg.prog_mode
                            & pin_sync[cpm_pkg::PIN_A6];
         end
         ccd_capture_q     <= alt_cfg.ccd_b7_enable
                            & pin_sync[cpm_pkg::PIN_B7];
      end
   end

   // checks
   property p_input_only;
      @(posedge clk) disable iff (!rst_n)
      pin_oe[cpm_pkg::PIN_A5] == 1'b0;
   endproperty
   a_input_only: assert property (p_input_only)
      else $error("input-only pin driven");

   property p_od_high;
      @(posedge clk) disable iff (!rst_n)
      ((pin_out & pin_oe & cpm_pkg::OPEN_DRAIN_MASK) == '0)
      && ((pin_pullup & cpm_pkg::OPEN_DRAIN_MASK) == '0);
   endproperty
   a_od_high: assert property (p_od_high)
      else $error("open-drain pin driven high or pulled up");

   property p_dir_oe;
      @(posedge clk) disable iff (!rst_n)
      (alt_own[cpm_pkg::PIN_A3] == 1'b0)
      |-> pin_oe[cpm_pkg::PIN_A3] == ~port_cfg.port_direction[cpm_pkg::PIN_A3];
   endproperty
   a_dir_oe: assert property (p_dir_oe)
      else $error("output enable does not follow direction");

   property p_adc;
      @(posedge clk) disable iff (!rst_n)
      adc_channel_select[4] |-> (port_cfg.port_direction[cpm_pkg::PIN_B1]
                                 && port_cfg.analog_select[cpm_pkg::PIN_B1]);
   endproperty
   a_adc: assert property (p_adc)
      else $error("channel selected without both bits");

   property p_test_out;
      @(posedge clk) disable iff (!rst_n)
      alt_cfg.test_out_enable |-> (pin_oe[cpm_pkg::PIN_A0]
         && pin_out[cpm_pkg::PIN_A0] == periph_out.test_out);
   endproperty
   a_test_out: assert property (p_test_out)
      else $error("test output not on pin a0");

   property p_sync_dir;
      @(posedge clk) disable iff (!rst_n)
      role_sync |-> pin_oe[cpm_pkg::PIN_A1] == role_main;
   endproperty
   a_sync_dir: assert property (p_sync_dir)
      else $error("sync pin direction wrong for role");

   sequence s_master_clear_input_low;
      alt_cfg.master_clear_enable && !pin_in[cpm_pkg::PIN_A5];
   endsequence
   property p_master_clear_input;
      @(posedge clk) disable iff (!rst_n)
      clk_en throughout (s_master_clear_input_low [*4]) |-> !master_clear_n_q;
   endproperty
   a_master_clear_input: assert property (p_master_clear_input)
      else $error("master clear not seen");

   property p_timer;
      @(posedge clk) disable iff (!rst_n)
      !alt_cfg.timer_clock_source_select && clk_en |=> !timer_ext_clock_q;
   endproperty
   a_timer: assert property (p_timer)
      else $error("timer clock routed while deselected");

   property p_desat;
      @(posedge clk) disable iff (!rst_n)
      desat_to_comparator != sense_amp_to_pin;
   endproperty
   a_desat: assert property (p_desat)
      else $error("desat pin owned twice");

   property p_scl_low;
      @(posedge clk) disable iff (!rst_n)
      alt_cfg.two_wire_enable && !alt_cfg.prog_mode
      |-> pin_oe[cpm_pkg::PIN_A7] == periph_out.scl_drive_low;
   endproperty
   a_scl_low: assert property (p_scl_low)
      else $error("bus clock pin drive wrong");

   property p_sda_low;
      @(posedge clk) disable iff (!rst_n)
      alt_cfg.two_wire_enable
      |-> pin_oe[cpm_pkg::PIN_B0] == periph_out.sda_drive_low;
   endproperty
   a_sda_low: assert property (p_sda_low)
      else $error("bus data pin drive wrong");

   property p_ref2_pin;
      @(posedge clk) disable iff (!rst_n)
      role_main |-> !pin_oe[cpm_pkg::PIN_B1] && !pin_pullup[cpm_pkg::PIN_B1];
   endproperty
   a_ref2_pin: assert property (p_ref2_pin)
      else $error("reference pin still driven digitally");

   property p_prime_hold;
      @(posedge clk) disable iff (!rst_n)
      !prime_q[P-2] |=> master_clear_n_q && scl_in_q && sda_in_q;
   endproperty
   a_prime_hold: assert property (p_prime_hold)
      else $error("idle level lost while synchroniser fills");

   property p_prime_change;
      @(posedge clk) disable iff (!rst_n)
      !prime_q[P-1] |=> change_flag_q == '0;
   endproperty
   a_prime_change: assert property (p_prime_change)
      else $error("change flag set before history is valid");
endmodule

// ==== design/cpm_sync.sv ====
module cpm_sync #(
   parameter int WIDTH = 16
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             clk_en,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;
   // meta_q feeds only sync_out; nothing else looks at it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else if (clk_en) begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule

// ==== inc/cpm_pkg.sv ====
// How it works
// - direction bit drives enable; pull-up, change detect
// - converter channel needs direction and analog bits
// - debug route puts test output on a0
// - main or secondary role takes a1 sync
// - timer clock select routes a2 to timer
// - external interrupt enable uses a2 as source
// - a5 is input only, never driven
// - master clear enable makes a5 reset input
// - a7 and b0 open drain, no pull-up
// - two-wire mode: a7 carries bus clock
// - two-wire mode: b0 carries bus data
// - main role puts second reference on b1
// - programming pins on a6/a7, also b4/b5
// - a6 and b7 belong to capture/compare unit
// - b7 compares out, captures in
// - sense pull-up enable bit powers pull-up
// - desat use routes pin to comparator
// - two-bit role field picks main/secondary/none
package cpm_pkg;
   localparam int NUM_PINS = 16;
   localparam int NUM_CH   = 8;
   // pin indices: port a 0..7, port b 8..15
   localparam int PIN_A0 = 0;
   localparam int PIN_A1 = 1;
   localparam int PIN_A2 = 2;
   localparam int PIN_A3 = 3;
   localparam int PIN_A5 = 5;
   localparam int PIN_A6 = 6;
   localparam int PIN_A7 = 7;
   localparam int PIN_B0 = 8;
   localparam int PIN_B1 = 9;
   localparam int PIN_B4 = 12;
   localparam int PIN_B5 = 13;
   localparam int PIN_B6 = 14;
   localparam int PIN_B7 = 15;
   // channel to pin map
   localparam int CH_PIN [NUM_CH] = '{0, 1, 2, 3, 9, 12, 13, 14};
   localparam logic [NUM_PINS-1:0] OPEN_DRAIN_MASK = 16'h0180;
   localparam logic [NUM_PINS-1:0] INPUT_ONLY_MASK = 16'h0020;
   localparam logic [NUM_PINS-1:0] DIR_RESET       = 16'hFFFF;
   // two sync stages plus one stage of change history
   localparam int PRIME_DEPTH = 3;
   localparam logic [1:0] ROLE_NONE      = 2'h0;
   localparam logic [1:0] ROLE_MAIN      = 2'h1;
   localparam logic [1:0] ROLE_SECONDARY = 2'h2;

   typedef struct packed {
      logic [NUM_PINS-1:0] port_direction;  // 1 = input
      logic [NUM_PINS-1:0] port_latch;
      logic [NUM_PINS-1:0] analog_select;
      logic [NUM_PINS-1:0] pullup_enable;
      logic [NUM_PINS-1:0] change_enable;
   } cpm_port_cfg_type;

   typedef struct packed {
      logic       test_out_enable;
      logic [1:0] unit_role_field;
      logic       timer_clock_source_select;
      logic       external_interrupt_enable;
      logic       master_clear_enable;
      logic       two_wire_enable;
      logic       prog_mode;
      logic       large_variant;
      logic       ccd_a6_enable;
      logic       ccd_b7_enable;
      logic       sense_input_pullup_enable;
      logic       desat_enable;
   } cpm_alt_cfg_type;

   typedef struct packed {
      logic test_out;
      logic sync_out;
      logic scl_drive_low;
      logic sda_drive_low;
      logic prog_data_out;
      logic prog_data_oe;
      logic ccd_a6_out;
      logic ccd_a6_oe;
      logic ccd_b7_out;
   } cpm_periph_out_type;
endpackage

// ==== test/cpm_board.sv ====
module cpm_board (
   input  wire logic        clk,
   input  wire logic [15:0] pin_out,
   input  wire logic [15:0] pin_oe,
   input  wire logic [15:0] pin_pullup,
   input  wire logic [15:0] ext_val,
   input  wire logic [15:0] ext_oe,
   output logic      [15:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // two-wire lines carry board pull-ups
   localparam logic [15:0] BUS_PULLUP = 16'h0180;
   // floating lines wander so a stale level never reads back
   logic [15:0] float_q = 16'h5A5A;
   always @(posedge clk) float_q <= ~float_q;
   // programmer clock and data arrive through ext
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         if (pin_oe[i]) pin_in[i] = pin_out[i];
         else if (ext_oe[i]) pin_in[i] = ext_val[i];
         else if (pin_pullup[i] | BUS_PULLUP[i]) pin_in[i] = 1'b1;
         else pin_in[i] = float_q[i];
      end
   end
endmodule

// ==== test/tb.sv ====
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] OD = cpm_pkg::OPEN_DRAIN_MASK;
   localparam logic [15:0] IO = cpm_pkg::INPUT_ONLY_MASK;
   logic                        clk = 1'b0;
   logic                        rst_n = 1'b0;
   logic                        clk_en = 1'b1;
   cpm_pkg::cpm_port_cfg_type   pcfg;
   cpm_pkg::cpm_alt_cfg_type    acfg;
   cpm_pkg::cpm_periph_out_type pout;
   logic [15:0]                 pin_in, pin_out, pin_oe, pin_pu;
   logic [15:0]                 rd_q, chg_q, chg_clr, ext_val, ext_oe;
   logic [7:0]                  adc;
   logic [8:0]                  regq;
   logic                        tmr, eint, master_clear_input_n, sync, scl, sda;
   logic                        pclk, pdat, cap, ref2, spu, dcmp, sfb, spin;
   int                          n_errors = 0;
   int                          n_tests = 0;

   always #25 clk = ~clk;
   assign regq = {tmr, eint, master_clear_input_n, sync, scl, sda, pclk, pdat, cap};

   cpm_pin_mux cpm_pin_mux_inst (
      .clk(clk), .rst_n(rst_n), .clk_en(clk_en),
      .port_cfg(pcfg), .alt_cfg(acfg), .periph_out(pout),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_pullup(pin_pu), .port_read_q(rd_q), .change_flag_q(chg_q),
      .change_clear(chg_clr), .adc_channel_select(adc),
      .timer_ext_clock_q(tmr), .ext_interrupt_q(eint),
      .master_clear_n_q(master_clear_input_n), .sync_in_q(sync), .scl_in_q(scl),
      .sda_in_q(sda), .prog_clock_q(pclk), .prog_data_in_q(pdat),
      .ccd_capture_q(cap), .ref2_to_pin_b1(ref2), .sense_pullup_on(spu),
      .desat_to_comparator(dcmp), .sense_amp_int_feedback(sfb),
      .sense_amp_to_pin(spin)
   );
   cpm_board cpm_board_inst (
      .clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_pullup(pin_pu), .ext_val(ext_val), .ext_oe(ext_oe),
      .pin_in(pin_in)
   );

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   // pin level must reach a registered input three edges later
   task automatic follow(input int p, input int b);
      for (int v = 0; v < 2; v++) begin
         ext_val[p] = v[0];
         cyc(3);
         check(16'(regq[b]), 16'(v[0]));
      end
   endtask

   function automatic logic [7:0] adc_exp(input logic [15:0] d,
                                          input logic [15:0] a);
      for (int c = 0; c < cpm_pkg::NUM_CH; c++) begin
         adc_exp[c] = d[cpm_pkg::CH_PIN[c]] & a[cpm_pkg::CH_PIN[c]];
      end
   endfunction

   task automatic tally_and_finish();
      $display("errors %0d tests %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      $display("mismatch at %0t: watchdog expired", $time);
      tally_and_finish();
   end

   initial begin
      logic [15:0] e;
      pcfg = '0;
      pcfg.port_direction = cpm_pkg::DIR_RESET;
      acfg = '0;
      pout = '0;
      chg_clr = '0;
      ext_val = '0;
      ext_oe = 16'hFFFF;
      void'($urandom(72191));
      cyc(6);
      check(pin_oe | pin_pu, 16'h0000);
      check(16'(regq), 16'h0058);
      check(16'(adc), 16'h0000);
      rst_n = 1'b1;
      // open-drain pins release on a high latch
      for (int k = 0; k < 24; k++) begin
         pcfg.port_direction = (k == 0) ? 16'h0000 : 16'($urandom);
         pcfg.port_latch = 16'($urandom);
         pcfg.pullup_enable = 16'($urandom);
         cyc(1);
         e = ~pcfg.port_direction & ~IO & ~(OD & pcfg.port_latch);
         check(pin_oe, e);
         check(pin_out & e & ~OD, pcfg.port_latch & e & ~OD);
         check(pin_out & pin_oe & OD, 16'h0000);
         e = pcfg.pullup_enable & (pcfg.port_direction | IO) & ~OD;
         check(pin_pu, e);
      end
      pcfg.pullup_enable = '0;
      for (int k = 0; k < 12; k++) begin
         e = (k == 0) ? 16'hFFFF : 16'($urandom);
         pcfg.port_direction = e;
         pcfg.analog_select = (k == 1) ? 16'hFFFF : 16'($urandom);
         ext_val = 16'($urandom);
         cyc(3);
         check(16'(adc), 16'(adc_exp(e, pcfg.analog_select)));
         check(rd_q & e, ext_val & ~pcfg.analog_select & e);
      end
      pcfg.analog_select = '0;
      pcfg.port_direction = 16'hFFFF;
      pcfg.change_enable = 16'hFFFF;
      cyc(4);
      chg_clr = 16'hFFFF;
      cyc(1);
      chg_clr = '0;
      for (int p = 0; p < 16; p++) begin
         ext_val[p] = ~ext_val[p];
         cyc(2);
         check(chg_q, 16'h0000);
         cyc(1);
         check(chg_q, 16'h0001 << p);
         chg_clr = 16'h0001 << p;
         cyc(1);
         chg_clr = '0;
      end
      // frozen edges must not advance the pipeline
      clk_en = 1'b0;
      ext_val[3] = ~ext_val[3];
      cyc(5);
      check(chg_q, 16'h0000);
      clk_en = 1'b1;
      cyc(3);
      check(chg_q, 16'h0008);
      acfg.test_out_enable = 1'b1;
      for (int v = 0; v < 2; v++) begin
         pout.test_out = v[0];
         cyc(1);
         check(16'({pin_oe[0], pin_out[0]}), 16'({1'b1, v[0]}));
      end
      acfg.test_out_enable = 1'b0;
      pout.sync_out = 1'b1;
      pcfg.port_direction[9] = 1'b0;
      for (int r = 0; r < 4; r++) begin
         acfg.unit_role_field = r[1:0];
         cyc(1);
         e = 16'({pin_oe[1], pin_out[1] & pin_oe[1], ref2, pin_oe[9]});
         check(e, 16'({r == 1, r == 1, r == 1, r != 1}));
         if (r == 2) follow(1, 5);
      end
      pcfg.port_direction[9] = 1'b1;
      acfg.timer_clock_source_select = 1'b1;
      follow(2, 8);
      acfg.external_interrupt_enable = 1'b1;
      follow(2, 7);
      acfg.master_clear_enable = 1'b1;
      follow(5, 6);
      ext_val[5] = 1'b0;
      cyc(5);
      check(16'(master_clear_input_n), 16'h0000);
      ext_val[5] = 1'b1;
      cyc(3);
      acfg.two_wire_enable = 1'b1;
      follow(7, 4);
      follow(8, 3);
      ext_oe = 16'hFE7F;
      pout.scl_drive_low = 1'b1;
      cyc(3);
      check(16'({pin_oe[8:7], pin_out[7], scl, sda}), 16'h0009);
      pout.scl_drive_low = 1'b0;
      pout.sda_drive_low = 1'b1;
      cyc(3);
      check(16'({pin_oe[8:7], pin_out[8], scl, sda}), 16'h0012);
      pout.sda_drive_low = 1'b0;
      cyc(3);
      check(16'({pin_oe[8:7], scl, sda}), 16'h0003);
      acfg.two_wire_enable = 1'b0;
      ext_oe = 16'hFFFF;
      acfg.prog_mode = 1'b1;
      follow(7, 2);
      follow(6, 1);
      acfg.large_variant = 1'b1;
      ext_val[7:6] = 2'h0;
      follow(13, 2);
      follow(12, 1);
      pout.prog_data_oe = 1'b1;
      pout.prog_data_out = 1'b1;
      cyc(1);
      e = 16'({pin_oe[6], pin_out[6], pin_oe[12], pin_out[12]});
      check(e, 16'h000F);
      acfg.prog_mode = 1'b0;
      acfg.ccd_a6_enable = 1'b1;
      acfg.ccd_b7_enable = 1'b1;
      pout.ccd_a6_oe = 1'b1;
      for (int v = 0; v < 2; v++) begin
         pout.ccd_a6_out = v[0];
         pout.ccd_b7_out = ~v[0];
         cyc(3);
         e = 16'({pin_oe[6], pin_out[6], pin_oe[15], pin_out[15]});
         check(e, 16'({1'b1, v[0], 1'b1, ~v[0]}));
         check(16'(cap), 16'({~v[0]}));
      end
      for (int s = 0; s < 4; s++) begin
         acfg.sense_input_pullup_enable = s[0];
         acfg.desat_enable = s[1];
         cyc(1);
         e = 16'({spu, dcmp, sfb, spin});
         check(e, 16'({s[0], s[1], s[1], ~s[1]}));
      end
      rst_n = 1'b0;
      cyc(1);
      check(16'(regq), 16'h0058);
      check(chg_q | rd_q, 16'h0000);
      rst_n = 1'b1;
      cyc(1);
      check(16'(regq), 16'h0058);
      cyc(3);
      check(chg_q, 16'h0000);
      tally_and_finish();
   end
endmodule
